// >>> omm_pkg.sv
// Contract
// - 256-byte identification map answers at device address 1010000X.
// - Diagnostics map answers at 1010001X; identification map never altered by it.
// - Data sampled on clock rise; stored only into unprotected locations.
// - Outgoing data bits change on clock fall.
// - Byte-wide memories, single and sequential access in one transaction.
// - Temperature, bias, TX power, RX power, supply readable live in diagnostics.
// - Alarm and warning flags set when value leaves factory range.
// - TX fault released high on laser fault, driven low otherwise.
// - Transmitter off when disable input high or open; on only when low.
// - Loss-of-signal released high when RX power too low, else low.
// - Module-absent pin tied low inside the module.
package omm_pkg;
	localparam logic [6:0] ID_DEV     = 7'h50;
	localparam logic [6:0] DG_DEV     = 7'h51;
	localparam logic [5:0] DEV_UPPER  = 6'h28;
	localparam int         MEM_DEPTH  = 256;
	localparam int         MON_W      = 16;
	localparam int         MON_N      = 5;
	localparam int         FLAG_N     = 2 * MON_N;
	localparam int         SYNC_N     = 3;
	localparam logic [7:0] LIVE_LO    = 8'h60;
	localparam logic [7:0] USER_LO    = 8'h80;
	localparam logic [7:0] MON_BASE   = 8'h60;
	localparam logic [7:0] ALM_OFS    = 8'h70;
	localparam logic [7:0] WRN_OFS    = 8'h74;
	localparam int         THR_STRIDE = 8;
	localparam int         THR_HA     = 0;
	localparam int         THR_LA     = 2;
	localparam int         THR_HW     = 4;
	localparam int         THR_LW     = 6;
	localparam logic [2:0] BIT_LAST   = 3'h7;
	localparam logic [5:0] FLAG_PAD   = 6'h00;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_AACK = 9'h004,
		ST_PTR  = 9'h008,
		ST_PACK = 9'h010,
		ST_WR   = 9'h020,
		ST_WACK = 9'h040,
		ST_RD   = 9'h080,
		ST_RACK = 9'h100
	} omm_state_t;
endpackage : omm_pkg

// >>> omm_sync_if.sv
interface omm_sync_if #(parameter int W = 3);
	logic         ce;
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport src (output ce, raw, input clean);
	modport snk (input ce, raw, output clean);
endinterface : omm_sync_if

// >>> omm_sync.sv
module omm_sync #(
	parameter int         W   = 3,
	parameter logic [W-1:0] RST = '1
) (
	input  wire logic i_clk,
	input  wire logic i_rst,
	omm_sync_if.snk   sp
);
	logic [W-1:0] ff1_q;
	logic [W-1:0] ff2_q;
	logic [W-1:0] ff3_q;
	logic [W-1:0] clean_q;
	logic [W-1:0] agree;

	assign agree    = ff2_q ~^ ff3_q;
	assign sp.clean = clean_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ff1_q   <= RST;
			ff2_q   <= RST;
			ff3_q   <= RST;
			clean_q <= RST;
		end else if (sp.ce) begin
			ff1_q   <= sp.raw;
			ff2_q   <= ff1_q;
			ff3_q   <= ff2_q;
			clean_q <= (agree & ff3_q) | (~agree & clean_q);
		end
	end
endmodule : omm_sync

// >>> omm_mgmt.sv
module omm_mgmt (
	input  wire logic                     I_CLK,
	input  wire logic                     I_RST,
	input  wire logic                     I_CE,
	input  wire logic                     I_SCL,
	input  wire logic                     I_SDA,
	output logic                          O_SDA_OUT,
	output logic                          O_SDA_OE,
	input  wire logic                     I_TX_DISABLE,
	output logic                          O_TX_ENABLE,
	input  wire logic                     I_LASER_FAULT,
	output logic                          O_TX_FAULT_OUT,
	output logic                          O_TX_FAULT_OE,
	input  wire logic                     I_RX_SIGNAL_LOST,
	output logic                          O_RX_SIGNAL_LOST_OUT,
	output logic                          O_RX_SIGNAL_LOST_OE,
	output logic                          O_MODULE_ABSENT_TIE_OUT,
	output logic                          O_MODULE_ABSENT_TIE_OE,
	input  wire logic                     I_PROG_EN,
	input  wire logic [omm_pkg::MON_W-1:0] I_TEMP,
	input  wire logic [omm_pkg::MON_W-1:0] I_VCC,
	input  wire logic [omm_pkg::MON_W-1:0] I_BIAS,
	input  wire logic [omm_pkg::MON_W-1:0] I_TXPWR,
	input  wire logic [omm_pkg::MON_W-1:0] I_RXPWR
);
	import omm_pkg::*;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	omm_sync_if #(.W(SYNC_N)) sif ();

	logic scl_c;
	logic sda_c;
	logic txd_c;
	logic scl_p_q;
	logic sda_p_q;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;

	assign sif.ce  = I_CE;
	assign sif.raw = {I_TX_DISABLE, I_SDA, I_SCL};
	assign scl_c   = sif.clean[0];
	assign sda_c   = sif.clean[1];
	assign txd_c   = sif.clean[2];

	omm_sync #(.W(SYNC_N)) u_sync (
		.i_clk (I_CLK),
		.i_rst (I_RST),
		.sp    (sif.snk)
	);

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else if (I_CE) begin
			scl_p_q <= scl_c;
			sda_p_q <= sda_c;
		end
	end

	assign scl_rise = scl_c & ~scl_p_q;
	assign scl_fall = ~scl_c & scl_p_q;
	assign start_ev = scl_c & scl_p_q & sda_p_q & ~sda_c;
	assign stop_ev  = scl_c & scl_p_q & ~sda_p_q & sda_c;

	// ------------------------------------------------------------
	// Memories and live values
	// ------------------------------------------------------------
	logic [7:0]       mem_id [MEM_DEPTH];
	logic [7:0]       mem_dg [MEM_DEPTH];
	logic [MON_W-1:0] mon_in [MON_N];
	logic [MON_W-1:0] mon_q  [MON_N];
	logic [FLAG_N-1:0] alm_d;
	logic [FLAG_N-1:0] wrn_d;
	logic [FLAG_N-1:0] alm_q;
	logic [FLAG_N-1:0] wrn_q;

	assign mon_in[0] = I_TEMP;
	assign mon_in[1] = I_VCC;
	assign mon_in[2] = I_BIAS;
	assign mon_in[3] = I_TXPWR;
	assign mon_in[4] = I_RXPWR;

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			for (int i = 0; i < MON_N; i++) begin
				mon_q[i] <= '0;
			end
		end else if (I_CE) begin
			for (int i = 0; i < MON_N; i++) begin
				mon_q[i] <= mon_in[i];
			end
		end
	end

	for (genvar p = 0; p < MON_N; p++) begin : g_thr
		localparam logic [7:0] B = 8'(p * THR_STRIDE);
		logic [MON_W-1:0] ha;
		logic [MON_W-1:0] la;
		logic [MON_W-1:0] hw;
		logic [MON_W-1:0] lw;
		assign ha = {mem_dg[B + 8'(THR_HA)], mem_dg[B + 8'(THR_HA + 1)]};
		assign la = {mem_dg[B + 8'(THR_LA)], mem_dg[B + 8'(THR_LA + 1)]};
		assign hw = {mem_dg[B + 8'(THR_HW)], mem_dg[B + 8'(THR_HW + 1)]};
		assign lw = {mem_dg[B + 8'(THR_LW)], mem_dg[B + 8'(THR_LW + 1)]};
		assign alm_d[FLAG_N-1-2*p] = mon_q[p] > ha;
		assign alm_d[FLAG_N-2-2*p] = mon_q[p] < la;
		assign wrn_d[FLAG_N-1-2*p] = mon_q[p] > hw;
		assign wrn_d[FLAG_N-2-2*p] = mon_q[p] < lw;
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			alm_q <= '0;
			wrn_q <= '0;
		end else if (I_CE) begin
			alm_q <= alm_d;
			wrn_q <= wrn_d;
		end
	end

	// ------------------------------------------------------------
	// Serial target
	// ------------------------------------------------------------
	omm_state_t state_q;
	logic [2:0] cnt_q;
	logic       got_q;
	logic [7:0] sh_q;
	logic [7:0] tx_q;
	logic [7:0] ptr_q;
	logic       sel_q;
	logic       rw_q;
	logic       mack_q;
	logic       oe_q;
	logic       dev_hit;
	logic       wr_ok;
	logic       counting;
	logic [7:0] live_byte;
	logic [7:0] rd_byte;

	// Only the two map addresses are claimed
	assign dev_hit  = (sh_q[7:2] == DEV_UPPER) &&
	                  ((sh_q[7:1] == ID_DEV) || (sh_q[7:1] == DG_DEV));
	assign counting = (state_q == ST_ADDR) || (state_q == ST_PTR) ||
	                  (state_q == ST_WR) || (state_q == ST_RD);

	// Live area is never writable; protected areas need I_PROG_EN
	always_comb begin
		if (sel_q) begin
			wr_ok = (ptr_q >= USER_LO) || (I_PROG_EN && (ptr_q < LIVE_LO));
		end else begin
			wr_ok = I_PROG_EN;
		end
	end

	always_comb begin
		live_byte = 8'h00;
		for (int i = 0; i < MON_N; i++) begin
			if (ptr_q == MON_BASE + 8'(2 * i)) begin
				live_byte = mon_q[i][MON_W-1:8];
			end
			if (ptr_q == MON_BASE + 8'(2 * i + 1)) begin
				live_byte = mon_q[i][7:0];
			end
		end
		if (ptr_q == ALM_OFS) begin
			live_byte = alm_q[FLAG_N-1:2];
		end
		if (ptr_q == ALM_OFS + 8'h01) begin
			live_byte = {alm_q[1:0], FLAG_PAD};
		end
		if (ptr_q == WRN_OFS) begin
			live_byte = wrn_q[FLAG_N-1:2];
		end
		if (ptr_q == WRN_OFS + 8'h01) begin
			live_byte = {wrn_q[1:0], FLAG_PAD};
		end
	end

	always_comb begin
		rd_byte = sel_q ? mem_dg[ptr_q] : mem_id[ptr_q];
		if (sel_q && (ptr_q >= LIVE_LO) && (ptr_q < USER_LO)) begin
			rd_byte = live_byte;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			state_q <= ST_IDLE;
			cnt_q   <= '0;
			got_q   <= 1'b0;
			sh_q    <= '0;
			tx_q    <= '0;
			ptr_q   <= '0;
			sel_q   <= 1'b0;
			rw_q    <= 1'b0;
			mack_q  <= 1'b0;
			oe_q    <= 1'b0;
		end else if (I_CE) begin
			if (start_ev) begin
				state_q <= ST_ADDR;
				cnt_q   <= '0;
				got_q   <= 1'b0;
				oe_q    <= 1'b0;
			end else if (stop_ev) begin
				state_q <= ST_IDLE;
				got_q   <= 1'b0;
				oe_q    <= 1'b0;
			end else if (scl_rise) begin
				if (state_q == ST_RACK) begin
					mack_q <= ~sda_c;
				end else if (counting) begin
					sh_q  <= {sh_q[6:0], sda_c};
					cnt_q <= cnt_q + 3'h1;
					got_q <= (cnt_q == BIT_LAST);
				end
			end else if (scl_fall) begin
				unique case (state_q)
					ST_IDLE: begin
					end
					ST_ADDR: begin
						if (got_q) begin
							got_q <= 1'b0;
							if (dev_hit) begin
								state_q <= ST_AACK;
								oe_q    <= 1'b1;
								sel_q   <= sh_q[1];
								rw_q    <= sh_q[0];
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
					ST_AACK: begin
						if (rw_q) begin
							state_q <= ST_RD;
							tx_q    <= rd_byte;
							oe_q    <= ~rd_byte[7];
						end else begin
							state_q <= ST_PTR;
							oe_q    <= 1'b0;
						end
					end
					ST_PTR: begin
						if (got_q) begin
							got_q   <= 1'b0;
							ptr_q   <= sh_q;
							state_q <= ST_PACK;
							oe_q    <= 1'b1;
						end
					end
					ST_PACK, ST_WACK: begin
						state_q <= ST_WR;
						oe_q    <= 1'b0;
					end
					ST_WR: begin
						if (got_q) begin
							got_q   <= 1'b0;
							ptr_q   <= ptr_q + 8'h01;
							state_q <= ST_WACK;
							oe_q    <= 1'b1;
						end
					end
					ST_RD: begin
						if (got_q) begin
							got_q   <= 1'b0;
							ptr_q   <= ptr_q + 8'h01;
							state_q <= ST_RACK;
							oe_q    <= 1'b0;
						end else begin
							tx_q <= {tx_q[6:0], 1'b0};
							oe_q <= ~tx_q[6];
						end
					end
					ST_RACK: begin
						if (mack_q) begin
							state_q <= ST_RD;
							tx_q    <= rd_byte;
							oe_q    <= ~rd_byte[7];
						end else begin
							state_q <= ST_IDLE;
						end
					end
				endcase
			end
		end
	end

	// Byte stored on the fall that ends the eighth bit
	always_ff @(posedge I_CLK) begin
		if (I_CE && !start_ev && !stop_ev && scl_fall && (state_q == ST_WR) && got_q && wr_ok) begin
			if (sel_q) begin
				mem_dg[ptr_q] <= sh_q;
			end else begin
				mem_id[ptr_q] <= sh_q;
			end
		end
	end

	assign O_SDA_OUT = 1'b0;
	assign O_SDA_OE  = oe_q;

	// ------------------------------------------------------------
	// Status and control pins
	// ------------------------------------------------------------
	logic tx_en_q;
	logic fault_oe_q;
	logic los_oe_q;

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			tx_en_q <= 1'b0;
		end else if (I_CE) begin
			tx_en_q <= ~txd_c;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			fault_oe_q <= 1'b1;
			los_oe_q   <= 1'b1;
		end else if (I_CE) begin
			fault_oe_q <= ~I_LASER_FAULT;
			los_oe_q   <= ~I_RX_SIGNAL_LOST;
		end
	end

	assign O_TX_ENABLE             = tx_en_q;
	assign O_TX_FAULT_OUT          = 1'b0;
	assign O_TX_FAULT_OE           = fault_oe_q;
	assign O_RX_SIGNAL_LOST_OUT    = 1'b0;
	assign O_RX_SIGNAL_LOST_OE     = los_oe_q;
	assign O_MODULE_ABSENT_TIE_OUT = 1'b0;
	assign O_MODULE_ABSENT_TIE_OE  = 1'b1;
endmodule : omm_mgmt

// >>> omm_mgmt_assertions.sv
module omm_mgmt_assertions (
	input  wire logic I_CLK,
	input  wire logic I_RST,
	input  wire logic I_CE,
	input  wire logic I_SCL,
	input  wire logic I_TX_DISABLE,
	input  wire logic I_LASER_FAULT,
	input  wire logic I_RX_SIGNAL_LOST,
	input  wire logic O_SDA_OUT,
	input  wire logic O_SDA_OE,
	input  wire logic O_TX_ENABLE,
	input  wire logic O_TX_FAULT_OUT,
	input  wire logic O_TX_FAULT_OE,
	input  wire logic O_RX_SIGNAL_LOST_OUT,
	input  wire logic O_RX_SIGNAL_LOST_OE,
	input  wire logic O_MODULE_ABSENT_TIE_OUT,
	input  wire logic O_MODULE_ABSENT_TIE_OE
);
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);
	// ----
	// Pin relations
	// ----
	AST_ABSENT_TIE: assert property (O_MODULE_ABSENT_TIE_OE && !O_MODULE_ABSENT_TIE_OUT)
		else $error("absent pin not grounded");
	AST_OPEN_DRAIN: assert property (!(O_TX_FAULT_OUT || O_RX_SIGNAL_LOST_OUT || O_SDA_OUT))
		else $error("open-drain output drives high");
	AST_FAULT_PIN: assert property (I_CE |=> O_TX_FAULT_OE == !$past(I_LASER_FAULT))
		else $error("fault pin does not follow laser fault");
	AST_LOS_PIN: assert property (I_CE |=> O_RX_SIGNAL_LOST_OE == !$past(I_RX_SIGNAL_LOST))
		else $error("signal-lost pin does not follow input");
	AST_TX_OFF: assert property ((I_CE && I_TX_DISABLE) [*6] |-> !O_TX_ENABLE)
		else $error("transmitter on while disabled");
	AST_TX_ON: assert property ((I_CE && !I_TX_DISABLE) [*6] |-> O_TX_ENABLE)
		else $error("transmitter off while enabled");
	// ----
	// Serial data drive and cover points
	// ----
	AST_OE_RISE: assert property ($rose(O_SDA_OE) |-> !I_SCL && $past(I_SCL, 8))
		else $error("data drive not launched by clock fall");
	AST_OE_BOUND: assert property ($rose(O_SDA_OE) |-> ##[1:300] !O_SDA_OE)
		else $error("data line held beyond one byte");
	COV_DRIVE: cover property ($rose(O_SDA_OE));
	COV_FAULT: cover property ($fell(O_TX_FAULT_OE));
	COV_TX_ON: cover property ($rose(O_TX_ENABLE));
endmodule : omm_mgmt_assertions

bind omm_mgmt omm_mgmt_assertions u_chk (
	.I_CLK(I_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_SCL(I_SCL),
	.I_TX_DISABLE(I_TX_DISABLE), .I_LASER_FAULT(I_LASER_FAULT),
	.I_RX_SIGNAL_LOST(I_RX_SIGNAL_LOST), .O_SDA_OUT(O_SDA_OUT), .O_SDA_OE(O_SDA_OE),
	.O_TX_ENABLE(O_TX_ENABLE), .O_TX_FAULT_OUT(O_TX_FAULT_OUT),
	.O_TX_FAULT_OE(O_TX_FAULT_OE), .O_RX_SIGNAL_LOST_OUT(O_RX_SIGNAL_LOST_OUT),
	.O_RX_SIGNAL_LOST_OE(O_RX_SIGNAL_LOST_OE),
	.O_MODULE_ABSENT_TIE_OUT(O_MODULE_ABSENT_TIE_OUT),
	.O_MODULE_ABSENT_TIE_OE(O_MODULE_ABSENT_TIE_OE)
);

// >>> omm_host.sv
module omm_host (
	input  wire logic i_clk,
	input  wire logic i_dev_oe,
	output logic      o_scl,
	output logic      o_sda
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int H = 14;
	logic pull_q;
	// ----
	// Open-drain data wire with pull-up
	// ----
	assign o_sda = !(pull_q || i_dev_oe);
	initial begin
		o_scl  = 1'b1;
		pull_q = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge i_clk);
	endtask : hold
	task automatic start();
		hold(2);
		pull_q = 1'b0;
		hold(H);
		o_scl = 1'b1;
		hold(H);
		pull_q = 1'b1;
		hold(H);
		o_scl = 1'b0;
	endtask : start
	task automatic stop();
		hold(2);
		pull_q = 1'b1;
		hold(H);
		o_scl = 1'b1;
		hold(H);
		pull_q = 1'b0;
		hold(H);
	endtask : stop
	task automatic bit_io(input logic b, output logic s);
		hold(2);
		pull_q = !b;
		hold(H);
		o_scl = 1'b1;
		hold(H / 2);
		s = o_sda;
		hold(H / 2);
		o_scl = 1'b0;
	endtask : bit_io
	task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] q,
		output logic nak);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(ack, nak);
	endtask : xfer
endmodule : omm_host

// >>> omm_mgmt_tb.sv
module omm_mgmt_tb;
	import omm_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic        tx_dis, fault, lost, prog, scl, sda, sda_oe, txen, flt_oe, los_oe;
	logic        abs_out, abs_oe;
	logic [15:0] mon [5];
	int          err_total = 0;
	int          checks = 0;

	always #2.5 clk = ~clk;

	omm_mgmt u_dut (
		.I_CLK(clk), .I_RST(rst), .I_CE(ce), .I_SCL(scl), .I_SDA(sda),
		.O_SDA_OUT(), .O_SDA_OE(sda_oe), .I_TX_DISABLE(tx_dis), .O_TX_ENABLE(txen),
		.I_LASER_FAULT(fault), .O_TX_FAULT_OUT(), .O_TX_FAULT_OE(flt_oe),
		.I_RX_SIGNAL_LOST(lost), .O_RX_SIGNAL_LOST_OUT(), .O_RX_SIGNAL_LOST_OE(los_oe),
		.O_MODULE_ABSENT_TIE_OUT(abs_out), .O_MODULE_ABSENT_TIE_OE(abs_oe),
		.I_PROG_EN(prog), .I_TEMP(mon[0]), .I_VCC(mon[1]), .I_BIAS(mon[2]),
		.I_TXPWR(mon[3]), .I_RXPWR(mon[4])
	);
	omm_host u_host (.i_clk(clk), .i_dev_oe(sda_oe), .o_scl(scl), .o_sda(sda));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic summarize();
		if (err_total == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize
	task automatic head(input logic [6:0] dev, input logic [7:0] ptr);
		logic [7:0] q;
		logic       n;
		u_host.start();
		u_host.xfer({dev, 1'b0}, 1'b1, q, n);
		u_host.xfer(ptr, 1'b1, q, n);
	endtask : head
	task automatic probe(input logic [6:0] dev, input logic nak);
		logic [7:0] q;
		logic       n;
		u_host.start();
		u_host.xfer({dev, 1'b0}, 1'b1, q, n);
		u_host.stop();
		chk({7'h00, n}, {7'h00, nak});
	endtask : probe
	task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d[$]);
		logic [7:0] q;
		logic       n;
		head(dev, ptr);
		foreach (d[i]) u_host.xfer(d[i], 1'b1, q, n);
		u_host.stop();
	endtask : wr
	task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] e[$]);
		logic [7:0] q;
		logic       n;
		head(dev, ptr);
		u_host.start();
		u_host.xfer({dev, 1'b1}, 1'b1, q, n);
		foreach (e[i]) begin
			u_host.xfer(8'hff, i == e.size() - 1, q, n);
			chk(q, e[i]);
		end
		u_host.stop();
	endtask : rd
	task automatic cur(input logic [6:0] dev, input logic [7:0] exp);
		logic [7:0] q;
		logic       n;
		u_host.start();
		u_host.xfer({dev, 1'b1}, 1'b1, q, n);
		u_host.xfer(8'hff, 1'b1, q, n);
		u_host.stop();
		chk(q, exp);
	endtask : cur

	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		summarize();
	end

	initial begin
		logic [7:0] th[$];
		logic [7:0] tv[8];
		tv     = '{8'h80, 8'h00, 8'h01, 8'h00, 8'h70, 8'h00, 8'h02, 8'h00};
		tx_dis = 1'b1; // Open pin reads high
		fault  = 1'b0;
		lost   = 1'b0;
		prog   = 1'b0;
		mon    = '{16'h9000, 16'h0050, 16'h0150, 16'h1234, 16'h7800};
		repeat (10) @(negedge clk);
		chk({5'h00, abs_oe, abs_out, txen}, 8'h04);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		chk({7'h00, txen}, 8'h00);
		tx_dis = 1'b0;
		repeat (8) @(negedge clk);
		chk({7'h00, txen}, 8'h01);
		fault = 1'b1;
		lost  = 1'b1;
		@(negedge clk);
		chk({6'h00, flt_oe, los_oe}, 8'h00);
		fault = 1'b0;
		lost  = 1'b0;
		@(negedge clk);
		chk({6'h00, flt_oe, los_oe}, 8'h03);
		// Clock enable low freezes pin state
		ce     = 1'b0;
		tx_dis = 1'b1;
		fault  = 1'b1;
		repeat (8) @(negedge clk);
		chk({6'h00, flt_oe, txen}, 8'h03);
		ce = 1'b1;
		repeat (8) @(negedge clk);
		chk({6'h00, flt_oe, txen}, 8'h00);
		fault  = 1'b0;
		tx_dis = 1'b0;
		repeat (8) @(negedge clk);
		chk({6'h00, flt_oe, txen}, 8'h03);
		probe(ID_DEV, 1'b0);
		probe(DG_DEV, 1'b0);
		probe(7'h52, 1'b1);
		probe(7'h10, 1'b1);
		prog = 1'b1;
		wr(ID_DEV, 8'hfe, '{8'h5a, 8'hc3, 8'h96});
		rd(ID_DEV, 8'hfe, '{8'h5a, 8'hc3, 8'h96});
		prog = 1'b0;
		wr(ID_DEV, 8'hfe, '{8'hff});
		wr(DG_DEV, 8'hfe, '{8'h77});
		rd(ID_DEV, 8'hfe, '{8'h5a});
		cur(ID_DEV, 8'hc3);
		rd(DG_DEV, 8'hfe, '{8'h77});
		prog = 1'b1;
		for (int p = 0; p < 40; p++) th.push_back(tv[p % 8]);
		wr(DG_DEV, 8'h00, th);
		wr(DG_DEV, 8'h60, '{8'hff});
		rd(DG_DEV, 8'h60, '{8'h90, 8'h00, 8'h00, 8'h50, 8'h01, 8'h50, 8'h12, 8'h34,
			8'h78, 8'h00});
		rd(DG_DEV, 8'h70, '{8'h90, 8'h00, 8'h00, 8'h00, 8'h94, 8'h80});
		prog = 1'b0;
		wr(DG_DEV, 8'h00, '{8'h00});
		rd(DG_DEV, 8'h00, '{8'h80});
		summarize();
	end
endmodule : omm_mgmt_tb
